/* File: lfs_analog_model.sv */
// partner: switching oscillator and switch current comparator
`timescale 1ns/1ps
`default_nettype none
module lfs_analog_model (
    input  wire logic       clk,
    input  wire logic [7:0] half_cyc,
    output logic            osc_tick,
    output logic            switch_current_trip,
    output logic [7:0]      phase
);
    import lfs_pkg::*;
    // ****
    // oscillator phase
    // ****
    logic [7:0] phase_q = 8'h00;
    // wrap on >= so a shorter period set mid-run cannot run away
    always_ff @(posedge clk) begin
        phase_q <= (phase_q >= {half_cyc[6:0], 1'b0} - 8'h01) ? 8'h00 : phase_q + 8'h01;
    end
    assign phase               = phase_q;
    // free-running: the internal oscillator never stops
    assign osc_tick            = phase_q < half_cyc;
    // early pulse falls inside blanking, late one ends the on-time
    assign switch_current_trip = (phase_q >= 8'h02 && phase_q < 8'h06) ||
                                 (phase_q >= 8'h1e && phase_q < 8'h22);
endmodule
`default_nettype wire

/* File: lfs_pkg.sv */
// package: constants and types for the led fault supervisor
package lfs_pkg;
    localparam int unsigned CLK_MHZ        = 250;
    // least times, in their own units
    localparam int unsigned SHORT_QUAL_NS  = 1000;
    localparam int unsigned BLANK_NS       = 50;
    localparam int unsigned RETRY_US       = 20;
    localparam int unsigned SHORT_QUAL_CYC = (SHORT_QUAL_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned BLANK_CYC      = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RETRY_CYC      = RETRY_US * CLK_MHZ;
    // oscillator cycle counts
    localparam int unsigned HICCUP_OSC     = 8192;
    localparam int unsigned BB_OSC         = 8192;
    localparam int unsigned CNT_W          = 14;
    localparam int unsigned TMR_W          = 13;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 14'h0000;

    typedef enum logic [2:0] {
        LFS_RUN    = 3'b001,
        LFS_HICCUP = 3'b010,
        LFS_RETRY  = 3'b100
    } lfs_state_t;
endpackage

/* File: lfs_supervisor.sv */
// top module: led driver fault and protection sequencer
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RQ1 - overvoltage: gate low, dim high, fault
// RQ2 - overvoltage cleared: restore drives, release fault
// RQ3 - fault open-drain low on ov/short/hot
// RQ4 - fault released when cause ends
// RQ5 - overtemperature: both transistors off
// RQ6 - re-enable after temperature hysteresis drop
// RQ7 - boost short qualified after one microsecond
// RQ8 - hiccup 8192 oscillator cycles, all off
// RQ9 - retry; fault clears after 20us clean
// RQ10 - hiccup can be omitted by option
// RQ11 - buck-boost short keeps regulating, detected
// RQ12 - up count 8192 cycles sets fault
// RQ13 - down count 8192 cycles clears fault
// RQ14 - ignore current sense 50ns blanking
// RQ15 - current trip ends on-time after blanking
// RQ16 - dim low: disconnect amp, dim high
// RQ17 - timers on oscillator, cleared by reset
// RQ18 - gate enable is dim and no faults; code masks only ov, hot, hiccup, not retry latch or buck-boost fault
module lfs_supervisor #(
    parameter bit HICCUP_EN = 1'b1
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic osc_tick,
    input  wire logic boost_mode,
    input  wire logic overvoltage_sense,
    input  wire logic over_temp,
    input  wire logic boost_short_sense,
    input  wire logic bb_short_sense,
    input  wire logic switch_current_trip,
    input  wire logic pulse_dim_input,
    output logic      switch_gate_drive,
    output logic      dim_gate_drive,
    output logic      amp_connect,
    output logic      fault_flag_n_o,
    output logic      fault_flag_n_oe
);
    import lfs_pkg::*;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] raw;
    assign raw = {osc_tick, boost_mode, overvoltage_sense, over_temp,
                  boost_short_sense, bb_short_sense, switch_current_trip, pulse_dim_input};
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    wire osc_s  = s2_q[7];
    wire boost  = s2_q[6];
    wire ov     = s2_q[5]; // comparator hysteresis is analog [RQ2]
    wire hot    = s2_q[4]; // detector hysteresis is analog [RQ6]
    wire bshort = s2_q[3];
    wire bbsh   = s2_q[2];
    wire itrip  = s2_q[1];
    wire dim    = s2_q[0];

    logic osc_d_q;
    always_ff @(posedge clk) begin
        if (!resetn) osc_d_q <= 1'b0;
        else osc_d_q <= osc_s;
    end
    wire cyc_start = osc_s & ~osc_d_q;

    // ************************************************************
    // boost short qualification and hiccup sequence
    // ************************************************************
    logic [8:0] qual_q;
    wire short_qual = HICCUP_EN && boost && (qual_q >= 9'(SHORT_QUAL_CYC)); // [RQ7] [RQ10]
    always_ff @(posedge clk) begin
        if (!resetn || !bshort || !boost) qual_q <= 9'h000;
        else if (!short_qual) qual_q <= qual_q + 9'h001;
    end

    lfs_state_t st_q;
    lfs_state_t st_d;
    logic [TMR_W-1:0] hic_q;
    logic [12:0]      rty_q;
    logic             latch_q;
    wire hic_done = cyc_start && (hic_q == TMR_W'(HICCUP_OSC - 1));
    wire rty_done = (rty_q == 13'(RETRY_CYC - 1));
    always_comb begin
        case (st_q)
            LFS_RUN:    st_d = short_qual ? LFS_HICCUP : LFS_RUN;
            LFS_HICCUP: st_d = hic_done ? LFS_RETRY : LFS_HICCUP; // [RQ8]
            LFS_RETRY:  st_d = short_qual ? LFS_HICCUP : (rty_done ? LFS_RUN : LFS_RETRY);
            default:    st_d = LFS_RUN;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin // [RQ17]
            st_q    <= LFS_RUN;
            hic_q   <= '0;
            rty_q   <= 13'h0000;
            latch_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            hic_q   <= (st_q != LFS_HICCUP) ? '0 : hic_q + TMR_W'(cyc_start); // [RQ17]
            rty_q   <= (st_q != LFS_RETRY) ? 13'h0000 : rty_q + 13'h0001;
            // set wins over the retry clear
            latch_q <= short_qual | (latch_q & ~(st_q == LFS_RETRY && rty_done)); // [RQ9]
        end
    end
    wire hiccup_off = (st_q == LFS_HICCUP);

    // ************************************************************
    // buck-boost short up/down counter
    // ************************************************************
    logic [CNT_W-1:0] bb_q;
    logic             bb_flt_q;
    wire bb_on = ~boost & bbsh; // switching continues in this case [RQ11]
    always_ff @(posedge clk) begin
        if (!resetn || boost) begin // [RQ17]
            bb_q     <= CNT_ZERO;
            bb_flt_q <= 1'b0;
        end else if (cyc_start) begin
            if (bb_on != bb_flt_q) begin
                if (bb_q == CNT_W'(BB_OSC - 1)) begin
                    bb_q     <= CNT_ZERO;
                    bb_flt_q <= bb_on; // [RQ12] [RQ13]
                end else begin
                    bb_q <= bb_q + 14'h0001;
                end
            end else begin
                bb_q <= CNT_ZERO; // consecutive cycles only
            end
        end
    end

    // ************************************************************
    // leading-edge blanking and peak current termination
    // ************************************************************
    logic [3:0] blank_q;
    logic       on_q;
    wire blanked = (blank_q != 4'h0); // [RQ14]
    always_ff @(posedge clk) begin
        if (!resetn) begin
            blank_q <= 4'h0;
            on_q    <= 1'b0;
        end else if (cyc_start) begin
            blank_q <= 4'(BLANK_CYC);
            on_q    <= 1'b1;
        end else begin
            if (blanked) blank_q <= blank_q - 4'h1;
            if (!blanked && itrip) on_q <= 1'b0; // [RQ15]
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    wire gate_en  = dim & ~ov & ~hot & ~hiccup_off; // [RQ18] [RQ1] [RQ5] [RQ16]
    wire fault    = ov | hot | hiccup_off | latch_q | bb_flt_q; // [RQ3] [RQ4] [RQ8]
    always_ff @(posedge clk) begin
        if (!resetn) begin
            switch_gate_drive <= 1'b0;
            dim_gate_drive    <= 1'b1;
            amp_connect       <= 1'b0;
            fault_flag_n_o    <= 1'b0;
            fault_flag_n_oe   <= 1'b1;
        end else begin
            switch_gate_drive <= gate_en & on_q & (cyc_start | ~itrip | blanked);
            dim_gate_drive    <= ~gate_en; // [RQ1] [RQ2] [RQ5] [RQ16]
            amp_connect       <= dim & ~hiccup_off; // [RQ8] [RQ16]
            fault_flag_n_o    <= 1'b0;
            fault_flag_n_oe   <= ~fault; // low pulls the line [RQ3]
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_ov_gate_off: assert property (@(posedge clk) disable iff (!resetn) // [RQ1]
        ov |=> !switch_gate_drive && dim_gate_drive && !fault_flag_n_oe)
        else $error("overvoltage did not shut drives");
    a_hot_off: assert property (@(posedge clk) disable iff (!resetn) // [RQ5]
        hot |=> !switch_gate_drive && dim_gate_drive)
        else $error("overtemperature did not shut drives");
    a_hiccup_hold: assert property (@(posedge clk) disable iff (!resetn) // [RQ8]
        hiccup_off |=> !switch_gate_drive && !amp_connect && !fault_flag_n_oe)
        else $error("hiccup outputs wrong");
    a_dim_low: assert property (@(posedge clk) disable iff (!resetn) // [RQ16]
        !dim |=> !amp_connect && dim_gate_drive)
        else $error("dim low not honoured");
    a_blank_ignore: assert property (@(posedge clk) disable iff (!resetn) // [RQ14]
        cyc_start |=> on_q [*4])
        else $error("blanking not held");
    a_trip_ends: assert property (@(posedge clk) disable iff (!resetn) // [RQ15]
        (!cyc_start && !blanked && itrip) |=> !on_q)
        else $error("trip did not end on-time");
    a_fault_free: assert property (@(posedge clk) disable iff (!resetn) // [RQ4]
        (!fault) |=> fault_flag_n_oe)
        else $error("fault flag not released");
    a_short_entry: assert property (@(posedge clk) disable iff (!resetn) // [RQ7]
        (short_qual && st_q == LFS_RUN) |=> hiccup_off)
        else $error("qualified short missed");
    a_bb_count: assert property (@(posedge clk) disable iff (!resetn) // [RQ12]
        $rose(bb_flt_q) |-> $past(bb_on) && $past(bb_q) == CNT_W'(BB_OSC - 1))
        else $error("buck-boost fault early");
    // last oscillator edge of the off time
    sequence s_hiccup_last;
        hiccup_off && hic_done;
    endsequence
    // full retry window with no qualified short
    sequence s_retry_clean;
        (st_q == LFS_RETRY) && rty_done && !short_qual;
    endsequence
    a_hiccup_exit: assert property (@(posedge clk) disable iff (!resetn) // [RQ8] [RQ9]
        s_hiccup_last |=> (st_q == LFS_RETRY) && latch_q && !fault_flag_n_oe)
        else $error("hiccup did not hand over to retry");
    a_retry_release: assert property (@(posedge clk) disable iff (!resetn) // [RQ9]
        s_retry_clean |=> !latch_q && (st_q == LFS_RUN))
        else $error("retry window did not clear the latch");
endmodule
`default_nettype wire

/* File: lfs_supervisor_test.sv */
// testbench: self-checking bench for the led fault supervisor
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor_test;
    import lfs_pkg::*;
    // ****
    // stimulus, model and checks
    // ****
    logic        clk        = 1'b0;
    logic        resetn     = 1'b0;
    logic        boost_mode = 1'b0;
    logic        ov         = 1'b0;
    logic        hot        = 1'b0;
    logic        b_short    = 1'b0;
    logic        bb_short   = 1'b0;
    logic        dim_in     = 1'b1;
    logic [7:0]  half_cyc   = 8'h28;
    logic [31:0] seed       = 32'h0000_005a;
    logic        en;
    logic [7:0]  phase;
    logic        osc_tick, trip, gate, dim_gate, amp, flt_o, flt_oe;
    logic        gate_nh, flt_oe_nh;
    wire         fault_line = flt_oe ? 1'b1 : flt_o; // pull-up when released
    int          fail_count = 0;
    int          num_checks = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    lfs_analog_model lfs_analog_model_i (.clk(clk), .half_cyc(half_cyc),
        .osc_tick(osc_tick), .switch_current_trip(trip), .phase(phase));
    lfs_supervisor lfs_supervisor_i (.clk(clk), .resetn(resetn), .osc_tick(osc_tick),
        .boost_mode(boost_mode), .overvoltage_sense(ov), .over_temp(hot),
        .boost_short_sense(b_short), .bb_short_sense(bb_short),
        .switch_current_trip(trip), .pulse_dim_input(dim_in),
        .switch_gate_drive(gate), .dim_gate_drive(dim_gate), .amp_connect(amp),
        .fault_flag_n_o(flt_o), .fault_flag_n_oe(flt_oe));
    // build without hiccup protection, same stimulus
    lfs_supervisor #(.HICCUP_EN(1'b0)) lfs_supervisor_nh_i (.clk(clk), .resetn(resetn),
        .osc_tick(osc_tick), .boost_mode(boost_mode), .overvoltage_sense(ov),
        .over_temp(hot), .boost_short_sense(b_short), .bb_short_sense(bb_short),
        .switch_current_trip(trip), .pulse_dim_input(dim_in),
        .switch_gate_drive(gate_nh), .dim_gate_drive(), .amp_connect(),
        .fault_flag_n_o(), .fault_flag_n_oe(flt_oe_nh));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait for an oscillator phase
    task automatic to_phase(input logic [7:0] p);
        for (int k = 0; k < 200 && phase !== p; k++) tick(1);
    endtask
    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        tick(15);
        check_bit(gate, 1'b0);
        check_bit(dim_gate, 1'b1);
        check_bit(amp, 1'b0);
        check_bit(fault_line, 1'b1);
        tick(1);
        resetn = 1'b1;
        $display("test reset done");
        // slow oscillator so blanking and trip both fit in one period
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            to_phase(8'h2d);
            {ov, hot, dim_in} = {seed[0] & seed[1], seed[2] & seed[3], seed[4] | seed[5]};
            to_phase(8'h14);
            en = dim_in & !ov & !hot;
            check_bit(gate, en);
            check_bit(dim_gate, !en);
            check_bit(amp, dim_in);
            check_bit(fault_line, !(ov | hot));
            to_phase(8'h28);
            check_bit(gate, 1'b0);
        end
        $display("test levels done");
        ov = 1'b0;
        hot = 1'b0;
        dim_in = 1'b1;
        half_cyc = 8'h03;
        boost_mode = 1'b1;
        b_short = 1'b1;
        tick(300);
        check_bit(gate_nh, 1'b1);
        check_bit(flt_oe_nh, 1'b1);
        b_short = 1'b0;
        tick(100);
        check_bit(fault_line, 1'b0);
        tick(47900);
        check_bit(gate, 1'b0);
        check_bit(amp, 1'b0);
        tick(1400);
        check_bit(gate, 1'b1);
        check_bit(fault_line, 1'b0);
        tick(5200);
        check_bit(fault_line, 1'b1);
        $display("test hiccup done");
        boost_mode = 1'b0;
        bb_short = 1'b1;
        tick(48850);
        check_bit(fault_line, 1'b1);
        tick(600);
        check_bit(fault_line, 1'b0);
        check_bit(gate, 1'b1);
        bb_short = 1'b0;
        tick(600);
        check_bit(fault_line, 1'b0);
        $display("test count done");
        test_done();
    end
    initial begin
        repeat (130000) @(posedge clk);
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
